// *** common/osc_ctrl_pkg.sv ***
// constants, register map and types of the internal oscillator control block
// assumes an 8-bit register port and one 200 MHz system clock
package osc_ctrl_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 8;
  localparam logic [7:0]  MAIN_SEL_ADDR  = 8'h00;
  localparam logic [7:0]  STATUS_ADDR    = 8'h01;
  localparam logic [7:0]  PROTECT_ADDR   = 8'h04;
  localparam logic [7:0]  FAST_CTRL_ADDR = 8'h10;
  localparam logic [7:0]  FAST_FREQ_ADDR = 8'h11;
  localparam logic [7:0]  FAST_TEMP_ADDR = 8'h12;
  localparam logic [7:0]  SLOW_CTRL_ADDR = 8'h18;
  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int          RUN_STANDBY_BIT = 1;
  localparam int          LOCK_BIT        = 7;
  localparam int          MAIN_SEL_BIT    = 0;
  localparam int          FREQ_TRIM_W     = 7;
  localparam int          TEMP_TRIM_W     = 4;
  localparam int          CHOICE_W        = 2;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  READ_ZERO       = 8'h00;
  localparam logic [1:0]  CHOICE_20M      = 2'h2;
  localparam int          STAT_SWITCH_BIT = 0;
  localparam int          STAT_FAST_GATE  = 1;
  localparam int          STAT_SLOW_GATE  = 2;
  localparam int          STAT_FAST_ON    = 3;
  localparam int          STAT_SLOW_ON    = 4;
  localparam int          STAT_PROT_OPEN  = 5;
  localparam logic        SRC_FAST        = 1'b0;
  localparam logic        SRC_SLOW        = 1'b1;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam logic [7:0]  PROTECT_KEY     = 8'hd8;  // arbitrary unlock key
  localparam logic [2:0]  PROTECT_WINDOW  = 3'h4;   // clk cycles the unlock stays open
  localparam logic [2:0]  GATE_OPEN_TICKS = 3'h4;   // oscillator cycles to open gate
  localparam logic [2:0]  ONE_TICK        = 3'h1;
  localparam logic [2:0]  NO_TICKS        = 3'h0;
  typedef enum logic [3:0] {
    GATE_IDLE  = 4'b0001,
    GATE_START = 4'b0010,
    GATE_COUNT = 4'b0100,
    GATE_OPEN  = 4'b1000
  } gate_state_t;
endpackage

// *** common/osc_gate_if.sv ***
// signals between the control core and one oscillator gate
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`default_nettype none
interface osc_gate_if;
  logic run_in_standby;  // keep oscillator running
  logic request;         // any consumer wants the clock
  logic tick;            // one oscillator cycle seen
  logic analog_ready;    // analog start-up finished
  logic osc_enable;      // oscillator powered
  logic gate_open;       // clock passed to consumers
  modport ctrl (output run_in_standby, request, tick, analog_ready,
                input osc_enable, gate_open);
  modport gate (input run_in_standby, request, tick, analog_ready,
                output osc_enable, gate_open);
endinterface
`default_nettype wire

// *** rtl/osc_gate.sv ***
// request-driven power and clock gate for one internal oscillator
// assumes tick is a one-cycle pulse per oscillator period
`timescale 1ns/1ps
`default_nettype none
module osc_gate (
  input  wire logic clk_i,         // system clock
  input  wire logic rst_i,         // synchronous reset, high
  osc_gate_if.gate  g              // oscillator side
);
  import osc_ctrl_pkg::*;

  gate_state_t state;
  logic [2:0]  ticks;

  // standby bit keeps the oscillator powered with no consumer
  assign g.osc_enable = g.run_in_standby | g.request;  // [RULE3]
  assign g.gate_open  = (state == GATE_OPEN);          // [RULE4]

  // a dropped request closes the gate at once, whatever the state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= GATE_IDLE;
    end else if (!g.request) begin
      state <= GATE_IDLE;                               // [RULE4]
    end else begin
      unique case (state)
        GATE_IDLE: begin
          // already running: skip the analog start-up wait
          state <= g.analog_ready ? GATE_COUNT : GATE_START;  // [RULE6]
        end
        GATE_START: begin
          if (g.analog_ready) state <= GATE_COUNT;
        end
        GATE_COUNT: begin
          if (g.tick && ticks == GATE_OPEN_TICKS - ONE_TICK) state <= GATE_OPEN;  // [RULE5]
        end
        GATE_OPEN: begin
          state <= GATE_OPEN;
        end
      endcase
    end
  end

  // oscillator cycles counted only while waiting to open
  always_ff @(posedge clk_i) begin
    if (rst_i || state != GATE_COUNT) begin
      ticks <= NO_TICKS;
    end else if (g.tick) begin
      ticks <= ticks + ONE_TICK;                        // [RULE5]
    end
  end
endmodule // osc_gate
`default_nettype wire

// *** rtl/main_clk_switch.sv ***
// main clock source switch with pending status
// assumes ready inputs are the gate-open flags of both oscillators
`timescale 1ns/1ps
`default_nettype none
module main_clk_switch (
  input  wire logic clk_i,         // system clock
  input  wire logic rst_i,         // synchronous reset, high
  input  wire logic target_i,      // wanted source
  input  wire logic fast_ready_i,  // fast clock stable at gate
  input  wire logic slow_ready_i,  // slow clock stable at gate
  output logic      current_o,     // source in use
  output logic      busy_o,        // switch pending
  output logic      fast_req_o,    // main clock needs fast osc
  output logic      slow_req_o     // main clock needs slow osc
);
  import osc_ctrl_pkg::*;

  logic target_ready;

  // old source stays requested until the new one has taken over
  assign target_ready = (target_i == SRC_SLOW) ? slow_ready_i : fast_ready_i;
  assign busy_o       = (current_o != target_i);              // [RULE1] [RULE2]
  assign fast_req_o   = (current_o == SRC_FAST) || (target_i == SRC_FAST);
  assign slow_req_o   = (current_o == SRC_SLOW) || (target_i == SRC_SLOW);

  // change only once the new source is stable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      current_o <= SRC_FAST;
    end else if (busy_o && target_ready) begin
      current_o <= target_i;                                  // [RULE1]
    end
  end
endmodule // main_clk_switch
`default_nettype wire

// *** rtl/osc_ctrl.sv ***
// control of the fast and slow internal oscillators and calibration of the fast one
// assumes fuse values are valid while reset is high and that all
// inputs, oscillator ticks included, are synchronous to clk_i
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Function
// (RULE1) switch status high while source change pending
// (RULE2) switch status low when no change pending
// (RULE3) run-in-standby keeps oscillator running always
// (RULE4) output gated off unless a peripheral requests
// (RULE5) gate opens four oscillator cycles after request
// (RULE6) run-in-standby skips analog start-up delay
// (RULE7) protected registers ignore unprotected writes
// (RULE8) seven-bit freq trim fine-tunes fast oscillator
// (RULE9) freq trim loaded from factory by fuse
// (RULE10) lock bit freezes both calibration registers
// (RULE11) lock bit loaded from fuse at reset
// (RULE12) four-bit temp trim sets compensation slope
// (RULE13) temp trim loaded from factory by fuse
// (RULE14) unused calibration bits read zero
module osc_ctrl (
  input  wire logic                                   clk_i,                      // 200 MHz clock
  input  wire logic                                   rst_i,                      // sync reset, high
  input  wire logic [osc_ctrl_pkg::ADDR_W-1:0]        addr_i,                     // register address
  input  wire logic [osc_ctrl_pkg::DATA_W-1:0]        wdata_i,                    // write data
  input  wire logic                                   wr_i,                       // write strobe
  input  wire logic                                   rd_i,                       // read strobe
  output logic      [osc_ctrl_pkg::DATA_W-1:0]        rdata_o,                    // read data, next cycle
  input  wire logic [osc_ctrl_pkg::CHOICE_W-1:0]      base_frequency_choice_i,    // fuse frequency select
  input  wire logic                                   trim_freeze_fuse_i,         // fuse lock bit
  input  wire logic [osc_ctrl_pkg::FREQ_TRIM_W-1:0]   factory_freq_trim_16_i,     // 16 MHz freq trim
  input  wire logic [osc_ctrl_pkg::FREQ_TRIM_W-1:0]   factory_freq_trim_20_i,     // 20 MHz freq trim
  input  wire logic [osc_ctrl_pkg::TEMP_TRIM_W-1:0]   factory_temp_trim_16_i,     // 16 MHz temp trim
  input  wire logic [osc_ctrl_pkg::TEMP_TRIM_W-1:0]   factory_temp_trim_20_i,     // 20 MHz temp trim
  input  wire logic                                   fast_req_i,                 // peripherals want fast osc
  input  wire logic                                   slow_req_i,                 // peripherals want slow osc
  input  wire logic                                   fast_tick_i,                // fast osc cycle pulse
  input  wire logic                                   slow_tick_i,                // slow osc cycle pulse
  input  wire logic                                   fast_osc_ready_i,           // fast analog start done
  input  wire logic                                   slow_osc_ready_i,           // slow analog start done
  output logic                                        fast_osc_enable_o,          // fast osc powered
  output logic                                        slow_osc_enable_o,          // slow osc powered
  output logic                                        fast_clk_gate_o,            // fast clock to peripherals
  output logic                                        slow_clk_gate_o,            // slow clock to peripherals
  output logic      [osc_ctrl_pkg::FREQ_TRIM_W-1:0]   freq_trim_o,                // to fast osc analog
  output logic      [osc_ctrl_pkg::TEMP_TRIM_W-1:0]   temp_slope_trim_o,          // to fast osc analog
  output logic                                        main_src_o,                 // 0 fast, 1 slow
  output logic                                        main_switch_busy_o          // source change pending
);
  import osc_ctrl_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  osc_gate_if fast_if ();
  osc_gate_if slow_if ();

  logic                   fast_run_in_standby;
  logic                   slow_run_in_standby;
  logic                   main_target;
  logic [FREQ_TRIM_W-1:0] freq_trim;
  logic [TEMP_TRIM_W-1:0] temp_slope_trim;
  logic                   trim_locked;
  logic [2:0]             protect_left;
  logic                   protect_open;
  logic                   key_write;
  logic                   prot_write;
  logic                   calib_write;
  logic                   main_fast_req;
  logic                   main_slow_req;
  logic                   main_current;
  logic                   switch_busy;
  logic [DATA_W-1:0]      next_rdata;
  logic [DATA_W-1:0]      status_word;
  logic                   fast_gate_seen;
  logic                   slow_gate_seen;

  // ****************************************************************
  // write protection
  // ****************************************************************

  // a key write opens a short window; one protected write spends it
  assign protect_open = (protect_left != NO_TICKS);
  assign key_write    = wr_i && (addr_i == PROTECT_ADDR) && (wdata_i == PROTECT_KEY);
  assign prot_write   = wr_i && protect_open && (addr_i != PROTECT_ADDR);   // [RULE7]
  // calibration needs both the window and an unlocked fuse
  assign calib_write  = prot_write && !trim_locked;                         // [RULE10]

  // window counter: key reloads, protected write or timeout closes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      protect_left <= NO_TICKS;
    end else if (key_write) begin
      protect_left <= PROTECT_WINDOW;                                       // [RULE7]
    end else if (prot_write) begin
      protect_left <= NO_TICKS;
    end else if (protect_open) begin
      protect_left <= protect_left - ONE_TICK;
    end
  end

  // ****************************************************************
  // oscillator control registers
  // ****************************************************************

  // only the run-in-standby bit is stored; the rest read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_run_in_standby <= CTRL_RESET[RUN_STANDBY_BIT];
    end else if (prot_write && addr_i == FAST_CTRL_ADDR) begin
      fast_run_in_standby <= wdata_i[RUN_STANDBY_BIT];                      // [RULE7]
    end
  end

  // slow oscillator keeps its own copy of the same bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slow_run_in_standby <= CTRL_RESET[RUN_STANDBY_BIT];
    end else if (prot_write && addr_i == SLOW_CTRL_ADDR) begin
      slow_run_in_standby <= wdata_i[RUN_STANDBY_BIT];                      // [RULE7]
    end
  end

  // main source choice; protected like the oscillator controls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_target <= SRC_FAST;
    end else if (prot_write && addr_i == MAIN_SEL_ADDR) begin
      main_target <= wdata_i[MAIN_SEL_BIT];
    end
  end

  // ****************************************************************
  // calibration registers
  // ****************************************************************

  // factory values picked by the fuse frequency choice at reset;
  // reset is synchronous so the fuse ports may feed the flops here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      if (base_frequency_choice_i == CHOICE_20M) begin
        freq_trim <= factory_freq_trim_20_i;                                // [RULE9]
      end else begin
        freq_trim <= factory_freq_trim_16_i;                                // [RULE9]
      end
    end else if (calib_write && addr_i == FAST_FREQ_ADDR) begin
      freq_trim <= wdata_i[FREQ_TRIM_W-1:0];                                // [RULE8] [RULE10]
    end
  end

  // temperature slope trim follows the same fuse choice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      if (base_frequency_choice_i == CHOICE_20M) begin
        temp_slope_trim <= factory_temp_trim_20_i;                          // [RULE13]
      end else begin
        temp_slope_trim <= factory_temp_trim_16_i;                          // [RULE13]
      end
    end else if (calib_write && addr_i == FAST_TEMP_ADDR) begin
      temp_slope_trim <= wdata_i[TEMP_TRIM_W-1:0];                          // [RULE12] [RULE10]
    end
  end

  // lock is read-only: software has no path to change it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trim_locked <= trim_freeze_fuse_i;                                    // [RULE11]
    end
  end

  // trims go straight to the analog oscillator from flops
  assign freq_trim_o       = freq_trim;                                     // [RULE8]
  assign temp_slope_trim_o = temp_slope_trim;                               // [RULE12]

  // ****************************************************************
  // oscillator gates
  // ****************************************************************

  // the main clock is a consumer too, so its needs join the requests
  assign fast_if.run_in_standby = fast_run_in_standby;                      // [RULE3]
  assign fast_if.request        = fast_req_i | main_fast_req;               // [RULE4]
  assign fast_if.tick           = fast_tick_i;
  assign fast_if.analog_ready   = fast_osc_ready_i;                         // [RULE6]
  assign slow_if.run_in_standby = slow_run_in_standby;                      // [RULE3]
  assign slow_if.request        = slow_req_i | main_slow_req;               // [RULE4]
  assign slow_if.tick           = slow_tick_i;
  assign slow_if.analog_ready   = slow_osc_ready_i;                         // [RULE6]

  // fast oscillator gate
  osc_gate u_fast_gate (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .g     (fast_if.gate)
  );

  // slow oscillator gate
  osc_gate u_slow_gate (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .g     (slow_if.gate)
  );

  // gate flags, shared by the status word and the switch
  assign fast_gate_seen    = fast_if.gate_open;
  assign slow_gate_seen    = slow_if.gate_open;
  assign fast_osc_enable_o = fast_if.osc_enable;                            // [RULE3]
  assign slow_osc_enable_o = slow_if.osc_enable;                            // [RULE3]
  // peripherals only see the clock once the gate has opened
  assign fast_clk_gate_o   = fast_gate_seen && fast_req_i;                  // [RULE4]
  assign slow_clk_gate_o   = slow_gate_seen && slow_req_i;                  // [RULE4]

  // ****************************************************************
  // main clock switch
  // ****************************************************************

  // the old source stays in use until the new gate reports open
  main_clk_switch u_switch (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .target_i     (main_target),
    .fast_ready_i (fast_gate_seen),
    .slow_ready_i (slow_gate_seen),
    .current_o    (main_current),
    .busy_o       (switch_busy),
    .fast_req_o   (main_fast_req),
    .slow_req_o   (main_slow_req)
  );

  assign main_src_o         = main_current;
  assign main_switch_busy_o = switch_busy;                                  // [RULE1] [RULE2]

  // ****************************************************************
  // read path
  // ****************************************************************

  // live status: switch pending, gates, power and unlock window
  always_comb begin
    status_word                  = READ_ZERO;
    status_word[STAT_SWITCH_BIT] = switch_busy;                             // [RULE1] [RULE2]
    status_word[STAT_FAST_GATE]  = fast_gate_seen;
    status_word[STAT_SLOW_GATE]  = slow_gate_seen;
    status_word[STAT_FAST_ON]    = fast_if.osc_enable;
    status_word[STAT_SLOW_ON]    = slow_if.osc_enable;
    status_word[STAT_PROT_OPEN]  = protect_open;
  end

  // read mux; unmapped and reserved bits give zero
  always_comb begin
    next_rdata = READ_ZERO;
    if (rd_i) begin
      unique case (addr_i)
        MAIN_SEL_ADDR:  next_rdata[MAIN_SEL_BIT]    = main_target;
        STATUS_ADDR:    next_rdata                  = status_word;
        FAST_CTRL_ADDR: next_rdata[RUN_STANDBY_BIT] = fast_run_in_standby;
        SLOW_CTRL_ADDR: next_rdata[RUN_STANDBY_BIT] = slow_run_in_standby;
        FAST_FREQ_ADDR: next_rdata[FREQ_TRIM_W-1:0] = freq_trim;            // [RULE14]
        FAST_TEMP_ADDR: begin
          next_rdata[TEMP_TRIM_W-1:0] = temp_slope_trim;                    // [RULE14]
          next_rdata[LOCK_BIT]        = trim_locked;
        end
        default:        next_rdata                  = READ_ZERO;
      endcase
    end
  end

  // data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= READ_ZERO;
    end else begin
      rdata_o <= next_rdata;
    end
  end

endmodule // osc_ctrl
`default_nettype wire

// *** testbench/osc_ctrl_chk.sv ***
// checker: port-level properties of the oscillator control block
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module osc_ctrl_chk
  import osc_ctrl_pkg::*;
(
  input wire logic                                 clk_i,                   // clock
  input wire logic                                 rst_i,                   // reset
  input wire logic [osc_ctrl_pkg::CHOICE_W-1:0]    base_frequency_choice_i, // fuse select
  input wire logic [osc_ctrl_pkg::FREQ_TRIM_W-1:0] factory_freq_trim_16_i,  // factory set
  input wire logic [osc_ctrl_pkg::FREQ_TRIM_W-1:0] factory_freq_trim_20_i,  // factory set
  input wire logic                                 trim_freeze_fuse_i,      // fuse lock
  input wire logic                                 fast_req_i,              // fast request
  input wire logic                                 slow_req_i,              // slow request
  input wire logic                                 slow_tick_i,             // slow cycle
  input wire logic                                 fast_clk_gate_o,         // fast gate
  input wire logic                                 slow_clk_gate_o,         // slow gate
  input wire logic [osc_ctrl_pkg::FREQ_TRIM_W-1:0] freq_trim_o,             // freq trim
  input wire logic [osc_ctrl_pkg::TEMP_TRIM_W-1:0] temp_slope_trim_o,       // temp trim
  input wire logic                                 main_src_o,              // main source
  input wire logic                                 main_switch_busy_o       // switch pending
);
  // ****************************************************************
  // helpers and properties
  // ****************************************************************
  logic [2:0] ticks;
  logic       lock_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ticks seen during a request; saturates so it cannot wrap to zero
  always_ff @(posedge clk_i) begin
    if (rst_i || !slow_req_i) ticks <= 3'h0;
    else if (slow_tick_i && ticks != 3'h7) ticks <= ticks + 3'h1;
  end
  // lock as fused at reset
  always_ff @(posedge clk_i) begin
    if (rst_i) lock_q <= trim_freeze_fuse_i;
  end
  sequence s_done;
    $past(main_switch_busy_o) ##0 !main_switch_busy_o;
  endsequence
  a_fast_gate_req: assert property (fast_clk_gate_o |-> fast_req_i)
    else $error("fast gate open without request");
  a_slow_gate_req: assert property (slow_clk_gate_o |-> slow_req_i)
    else $error("slow gate open without request");
  a_slow_gate_hold: assert property (slow_clk_gate_o && slow_req_i |=> slow_clk_gate_o || !slow_req_i)
    else $error("slow gate closed under request");
  a_gate_four_ticks: assert property ($rose(slow_clk_gate_o) |-> ticks >= 3'h4)
    else $error("slow gate opened before four cycles");
  a_switch_done: assert property ($changed(main_src_o) |-> s_done)
    else $error("source changed outside pending switch");
  a_busy_settles: assert property ($rose(main_switch_busy_o) |-> ##[1:300] !main_switch_busy_o)
    else $error("switch status stuck high");
  a_freq_reset_load: assert property ($fell(rst_i) |-> freq_trim_o == ((base_frequency_choice_i
      == CHOICE_20M) ? factory_freq_trim_20_i : factory_freq_trim_16_i))
    else $error("freq trim not loaded at reset");
  a_lock_freeze: assert property (lock_q |-> $stable(freq_trim_o) && $stable(temp_slope_trim_o))
    else $error("trim changed while locked");
endmodule // osc_ctrl_chk
bind osc_ctrl osc_ctrl_chk i_osc_ctrl_chk (.*);
`default_nettype wire

// *** testbench/osc_ctrl_bench.sv ***
// self-checking bench for the oscillator control block
// assumes the design package and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module osc_ctrl_bench;
  import osc_ctrl_pkg::*;
  // ****************************************************************
  // stimulus, model queue and checks
  // ****************************************************************
  logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, trim_freeze_fuse_i = 1'b0;
  logic fast_req_i = 1'b0, slow_req_i = 1'b0, fast_tick_i = 1'b0, slow_tick_i = 1'b0;
  logic fast_osc_ready_i = 1'b1, slow_osc_ready_i = 1'b1, rd_seen = 1'b0;
  logic fast_osc_enable_o, slow_osc_enable_o, fast_clk_gate_o, slow_clk_gate_o;
  logic main_src_o, main_switch_busy_o;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, exp_q[$];
  logic [1:0] base_frequency_choice_i = 2'h0, tick_div = 2'h0;
  logic [6:0] factory_freq_trim_16_i = 7'h00, factory_freq_trim_20_i = 7'h00, freq_trim_o, ftrim;
  logic [3:0] factory_temp_trim_16_i = 4'h0, factory_temp_trim_20_i = 4'h0, temp_slope_trim_o, ttrim;
  int err_total = 0, total_checks = 0, cycles = 0, seed = 87, i;
  osc_ctrl i_osc_ctrl (.*);
  // flags polled by wait_for: 0 slow gate, 1 fast gate, 2 main source
  logic [2:0] watch;
  assign watch = {main_src_o, fast_clk_gate_o, slow_clk_gate_o};
  always #2.5 clk_i = ~clk_i;
  // oscillator cycles every fourth clock, offset so both are seen
  always @(posedge clk_i) begin
    tick_div <= tick_div + 2'h1;
    fast_tick_i <= (tick_div == 2'h0);
    slow_tick_i <= (tick_div == 2'h2);
    // analog ready trails the enable by a clock, so a cold start must wait
    fast_osc_ready_i <= fast_osc_enable_o;
    slow_osc_ready_i <= slow_osc_enable_o;
    rd_seen <= rd_i;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      $display("BAD %0t timeout", $time);
      test_done();
    end
  end
  // read data settle at the edge after the strobe; compare mid-cycle
  always @(negedge clk_i) if (rd_seen) chk(rdata_o, exp_q.pop_front());
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic pwr(input logic [7:0] a, input logic [7:0] d);
    wr(PROTECT_ADDR, PROTECT_KEY);
    wr(a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a; rd_i <= 1'b1; exp_q.push_back(exp);
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  // bounded wait on a watched flag, then compare it; read live, a copy would go stale
  task automatic wait_for(input int b, input logic v);
    for (int k = 0; k < 60 && watch[b] !== v; k++) @(posedge clk_i);
    @(negedge clk_i);
    chk(8'(watch[b]), 8'(v));
  endtask
  task automatic do_reset(input logic lk, input logic [1:0] ch);
    @(posedge clk_i);
    rst_i <= 1'b1; trim_freeze_fuse_i <= lk; base_frequency_choice_i <= ch;
    factory_freq_trim_16_i <= 7'($random(seed)); factory_freq_trim_20_i <= 7'($random(seed));
    factory_temp_trim_16_i <= 4'($random(seed)); factory_temp_trim_20_i <= 4'($random(seed));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    ftrim = (ch == CHOICE_20M) ? factory_freq_trim_20_i : factory_freq_trim_16_i;
    ttrim = (ch == CHOICE_20M) ? factory_temp_trim_20_i : factory_temp_trim_16_i;
  endtask
  task automatic test_done();
    repeat (2) @(negedge clk_i);
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    do_reset(1'b0, 2'($random(seed)) & 2'h1); // 16 MHz set first
    rd(FAST_FREQ_ADDR, {1'b0, ftrim});
    rd(FAST_TEMP_ADDR, {4'h0, ttrim});
    wr(FAST_FREQ_ADDR, {1'b0, ~ftrim});
    rd(FAST_FREQ_ADDR, {1'b0, ftrim});
    for (i = 0; i < 3; i++) begin
      ftrim = 7'($random(seed));
      pwr(FAST_FREQ_ADDR, {1'b1, ftrim});
      rd(FAST_FREQ_ADDR, {1'b0, ftrim});
      chk(8'(freq_trim_o), 8'(ftrim));
    end
    pwr(FAST_TEMP_ADDR, 8'hff);
    rd(FAST_TEMP_ADDR, 8'h0f);
    chk(8'(temp_slope_trim_o), 8'h0f);
    rd(8'h3f, 8'h00);
    chk(8'(slow_osc_enable_o), 8'h00);
    pwr(SLOW_CTRL_ADDR, 8'h02);
    rd(SLOW_CTRL_ADDR, 8'h02);
    chk(8'(slow_osc_enable_o), 8'h01);
    // peripheral request on the running slow oscillator
    @(posedge clk_i) slow_req_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk(8'(slow_clk_gate_o), 8'h00);
    wait_for(0, 1'b1);
    @(posedge clk_i) slow_req_i <= 1'b0;
    wait_for(0, 1'b0);
    // main source to slow and back
    pwr(MAIN_SEL_ADDR, 8'h01);
    @(negedge clk_i) chk(8'(main_switch_busy_o), 8'h01);
    rd(STATUS_ADDR, 8'h1b);
    wait_for(2, SRC_SLOW);
    chk(8'(main_switch_busy_o), 8'h00);
    chk(8'(fast_osc_enable_o), 8'h00);
    rd(MAIN_SEL_ADDR, 8'h01);
    // cold fast oscillator: start-up wait, then four cycles
    @(posedge clk_i) fast_req_i <= 1'b1;
    wait_for(1, 1'b1);
    pwr(MAIN_SEL_ADDR, 8'h00);
    wait_for(2, SRC_FAST);
    rd(STATUS_ADDR, 8'h1a);
    // second reset with the lock fused
    do_reset(1'b1, CHOICE_20M);
    rd(FAST_TEMP_ADDR, {4'h8, ttrim});
    pwr(FAST_FREQ_ADDR, {1'b0, ~ftrim});
    rd(FAST_FREQ_ADDR, {1'b0, ftrim});
    test_done();
  end
endmodule // osc_ctrl_bench
`default_nettype wire
